// >>> adr_defs.svh
// constants of the actuator drive configuration register block
// assumes inclusion by the block itself; the package needs none of it
`ifndef ADR_DEFS_SVH
`define ADR_DEFS_SVH
// register byte addresses
`define ADR_CFG_OFS     8'h00
`define ADR_STAT_OFS    8'h04
// configuration field positions
`define ADR_GATE_HI     7
`define ADR_GATE_LO     6
`define ADR_ERM_BIT     5
`define ADR_COMP_BIT    4
`define ADR_SIGN_BIT    3
`define ADR_RATE_BIT    2
`define ADR_INSEL_BIT   1
`define ADR_LRA_BIT     0
`define ADR_CFG_RESET   8'h80
// gate thresholds on a 0..255 amplitude scale
`define ADR_GATE_2PCT   8'h05
`define ADR_GATE_4PCT   8'h0a
`define ADR_GATE_8PCT   8'h14
// device mode that uses the external input
`define ADR_MODE_EXT    3'h3
// input cycles per commutation period
`define ADR_COMM_DIV    128
// duty measuring window in clock cycles
`define ADR_DUTY_WIN    256
`endif

// >>> adr_pkg.sv
// types of the actuator drive configuration register block
// assumes adr_defs.svh holds the numbers
package adr_pkg;
   // input path state, one-hot
   typedef enum logic [2:0] {
      ADR_IN_OFF    = 3'b001,
      ADR_IN_PWM    = 3'b010,
      ADR_IN_ANALOG = 3'b100
   } adr_in_e;
   typedef logic [7:0] adr_byte_t;
endpackage

// >>> adr_drive_config.sv
// actuator drive configuration register with AHB-Lite access,
// input amplitude recovery, noise gate and resonant commutation
// assumes one clock hclk; external pin and level are asynchronous
//
// Contract
// R1 - bits 7:6 noise gate, reset code 2
// R2 - bit 5 eccentric mass open loop
// R3 - bit 4 disables supply compensation
// R4 - bit 3 realtime data unsigned when set
// R5 - bit 2 amplitude updates twice per cycle
// R6 - bit 1 analog input in mode 3
// R7 - amplitude from duty or from level
// R8 - bit 0 resonant open loop drive
// R9 - commutation equals pwm frequency over 128
// R10 - source gives 128 times resonant frequency
// R11 - read returns all bits, reset 0x80
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
`include "adr_defs.svh"
module adr_drive_config #(
   parameter int DUTY_WIN = `ADR_DUTY_WIN
) (
   // clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // ahb-lite slave
   input  wire logic             hsel,
   input  wire logic [7:0]       haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic      [31:0]      hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   // device context and pins
   input  wire logic [2:0]       device_mode,
   input  wire logic             external_input_pin,
   input  wire adr_pkg::adr_byte_t analog_level,
   input  wire adr_pkg::adr_byte_t realtime_playback,
   // controls to the drive engine
   output logic                  eccentric_mass_loop_select,
   output logic                  supply_compensation_off,
   output logic                  resonant_loop_select,
   output logic                  resonant_update_rate,
   output adr_pkg::adr_byte_t    input_amplitude,
   output adr_pkg::adr_byte_t    realtime_magnitude,
   output logic                  commutation,
   output logic                  amplitude_update
);
   import adr_pkg::*;

   localparam int HALF_DIV = `ADR_COMM_DIV / 2;

   // configuration register and bus tracking
   adr_byte_t   drive_mode_config;
   adr_byte_t   next_cfg;
   logic        wr_pend;
   logic [7:0]  wr_addr;
   logic        rd_dummy;

   // address phase decode
   wire         take       = hsel & hready & htrans[1];
   wire         hit_cfg    = (haddr == `ADR_CFG_OFS);
   wire         hit_stat   = (haddr == `ADR_STAT_OFS);
   wire         cfg_write  = wr_pend & (wr_addr == `ADR_CFG_OFS);

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // data phase write lands in the register
   always_comb begin
      next_cfg = drive_mode_config;
      if (cfg_write) begin
         next_cfg = hwdata[7:0]; // R11
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         drive_mode_config <= `ADR_CFG_RESET; // R1 R11
         wr_pend           <= 1'b0;
         wr_addr           <= 8'h00;
      end else begin
         drive_mode_config <= next_cfg;
         wr_pend           <= take & hwrite;
         wr_addr           <= haddr;
      end
   end

   // field decode
   wire [1:0]   gate_code  = drive_mode_config[`ADR_GATE_HI:`ADR_GATE_LO];
   wire         use_ext    = (device_mode == `ADR_MODE_EXT); // R6
   wire         sel_analog = drive_mode_config[`ADR_INSEL_BIT]; // R6
   assign eccentric_mass_loop_select = drive_mode_config[`ADR_ERM_BIT]; // R2
   assign supply_compensation_off    = drive_mode_config[`ADR_COMP_BIT]; // R3
   assign resonant_update_rate       = drive_mode_config[`ADR_RATE_BIT]; // R5
   assign resonant_loop_select       = drive_mode_config[`ADR_LRA_BIT]; // R8

   // pin and level synchronisers
   logic        pin_s1;
   logic        pin_s2;
   logic        pin_d;
   adr_byte_t   lvl_s1;
   adr_byte_t   lvl_s2;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         pin_d  <= 1'b0;
         lvl_s1 <= 8'h00;
         lvl_s2 <= 8'h00;
      end else begin
         pin_s1 <= external_input_pin;
         pin_s2 <= pin_s1;
         pin_d  <= pin_s2;
         lvl_s1 <= analog_level;
         lvl_s2 <= lvl_s1;
      end
   end

   wire pin_rise = pin_s2 & ~pin_d;

   // input path state
   adr_in_e     in_state;
   adr_in_e     next_in_state;

   always_comb begin
      case ({use_ext, sel_analog})
         2'b10:   next_in_state = ADR_IN_PWM;
         2'b11:   next_in_state = ADR_IN_ANALOG;
         default: next_in_state = ADR_IN_OFF;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_state <= ADR_IN_OFF;
      end else begin
         in_state <= next_in_state;
      end
   end

   // duty measurement over a fixed window of clock cycles
   logic [15:0] win_cnt;
   logic [15:0] high_cnt;
   adr_byte_t   duty;
   wire         win_end  = (win_cnt == 16'(DUTY_WIN - 1));
   wire [15:0]  high_nxt = high_cnt + 16'(pin_s2);
   wire [15:0]  duty_w   = (high_nxt * 16'd255) / 16'(DUTY_WIN);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         win_cnt  <= 16'h0000;
         high_cnt <= 16'h0000;
         duty     <= 8'h00;
      end else if (win_end) begin
         win_cnt  <= 16'h0000;
         high_cnt <= 16'h0000;
         duty     <= duty_w[7:0]; // R7
      end else begin
         win_cnt  <= win_cnt + 16'h0001;
         high_cnt <= high_nxt;
      end
   end

   // amplitude source and noise gate
   adr_byte_t   gate_lvl;
   adr_byte_t   raw_amp;

   always_comb begin
      case (gate_code)
         2'h1:    gate_lvl = `ADR_GATE_2PCT; // R1
         2'h2:    gate_lvl = `ADR_GATE_4PCT; // R1
         2'h3:    gate_lvl = `ADR_GATE_8PCT; // R1
         default: gate_lvl = 8'h00;
      endcase
      case (in_state)
         ADR_IN_PWM:    raw_amp = duty; // R7
         ADR_IN_ANALOG: raw_amp = lvl_s2; // R7
         default:       raw_amp = 8'h00;
      endcase
   end

   wire gated = (gate_code != 2'h0) & (raw_amp < gate_lvl);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         input_amplitude <= 8'h00;
      end else begin
         input_amplitude <= gated ? 8'h00 : raw_amp; // R1
      end
   end

   // realtime data to magnitude, signed values take their absolute value
   wire       rt_neg = realtime_playback[7];
   wire [7:0] rt_abs = rt_neg ? 8'(~realtime_playback + 8'h01) : realtime_playback;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         realtime_magnitude <= 8'h00;
      end else if (drive_mode_config[`ADR_SIGN_BIT]) begin
         realtime_magnitude <= realtime_playback; // R4
      end else begin
         realtime_magnitude <= rt_abs; // R4
      end
   end

   // commutation from pwm edges: toggle every half of the divide
   logic [6:0]  edge_cnt;
   wire         comm_run  = resonant_loop_select & (in_state == ADR_IN_PWM);
   wire         half_done = (edge_cnt == 7'(HALF_DIV - 1));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         edge_cnt    <= 7'h00;
         commutation <= 1'b0;
      end else if (!comm_run) begin
         edge_cnt    <= 7'h00;
         commutation <= 1'b0;
      end else if (pin_rise) begin // R9 R10
         edge_cnt    <= half_done ? 7'h00 : edge_cnt + 7'h01;
         commutation <= commutation ^ half_done; // R9
      end
   end

   // amplitude update strobe, one or both commutation edges
   logic comm_d;
   wire  comm_rise = commutation & ~comm_d;
   wire  comm_fall = ~commutation & comm_d;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         comm_d           <= 1'b0;
         amplitude_update <= 1'b0;
      end else begin
         comm_d           <= commutation;
         amplitude_update <= comm_rise | (resonant_update_rate & comm_fall); // R5
      end
   end

   // read data registered in the address phase
   wire [31:0] stat_word = {19'h0, commutation, in_state, input_amplitude, 1'b0};
   wire [31:0] rd_mux = hit_cfg  ? {24'h0, next_cfg} :
                        hit_stat ? stat_word : 32'h0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (take & ~hwrite) begin
         hrdata <= rd_mux; // R11
      end
   end

   assign rd_dummy = |hsize;

   // checks
   sequence s_cfg_wr;
      cfg_write;
   endsequence

   sequence s_cfg_rd;
      take & ~hwrite & hit_cfg;
   endsequence

   a_cfg_write_lands: assert property (@(posedge hclk) disable iff (!hresetn) // R11
      s_cfg_wr |=> drive_mode_config == $past(hwdata[7:0]))
      else $error("config write lost");

   a_cfg_read_back: assert property (@(posedge hclk) disable iff (!hresetn) // R11
      s_cfg_rd |=> hrdata[7:0] == drive_mode_config && hrdata[31:8] == 24'h0)
      else $error("config read mismatch");

   a_gate_blocks: assert property (@(posedge hclk) disable iff (!hresetn) // R1
      (gate_code == 2'h3 && raw_amp < 8'h14) |=> input_amplitude == 8'h00)
      else $error("gate passed small input");

   a_erm_follows: assert property (@(posedge hclk) disable iff (!hresetn) // R2
      s_cfg_wr |=> eccentric_mass_loop_select == $past(hwdata[5]))
      else $error("eccentric loop wrong");

   a_comp_follows: assert property (@(posedge hclk) disable iff (!hresetn) // R3
      s_cfg_wr |=> supply_compensation_off == $past(hwdata[4]))
      else $error("compensation bit wrong");

   a_rt_unsigned: assert property (@(posedge hclk) disable iff (!hresetn) // R4
      drive_mode_config[3] |=> realtime_magnitude == $past(realtime_playback))
      else $error("unsigned realtime wrong");

   a_update_once: assert property (@(posedge hclk) disable iff (!hresetn) // R5
      (comm_fall && !resonant_update_rate) |=> !amplitude_update)
      else $error("extra amplitude update");

   a_analog_path: assert property (@(posedge hclk) disable iff (!hresetn) // R6 R7
      (use_ext && sel_analog) |=> in_state == ADR_IN_ANALOG)
      else $error("analog path not chosen");

   a_comm_toggle: assert property (@(posedge hclk) disable iff (!hresetn) // R9
      (comm_run && pin_rise && !half_done) |=> $stable(commutation))
      else $error("commutation toggled early");

   a_lra_follows: assert property (@(posedge hclk) disable iff (!hresetn) // R8
      s_cfg_wr |=> resonant_loop_select == $past(hwdata[0]))
      else $error("resonant loop wrong");
endmodule

// >>> adr_in_source.sv
// external pwm and analog source facing the drive config block
// assumes the bench sets period and high time in hclk cycles
`timescale 1ns/1ns
module adr_in_source (
   // clock
   input  wire logic       hclk,
   // bench controls
   input  wire logic       run,
   input  wire logic [7:0] period,
   input  wire logic [7:0] high,
   input  wire logic [7:0] level,
   // pins to the block
   output logic            pin,
   output logic [7:0]      analog
);
   logic [7:0] cnt = 8'h00;
   initial pin = 1'b0;
   // pwm at 128 times the resonant rate, low while stopped
   always @(posedge hclk) begin
      cnt <= (!run || cnt == period - 8'h01) ? 8'h00 : cnt + 8'h01;
      pin <= run && (cnt < high);
   end
   // level held steady between bench changes
   assign analog = level;
endmodule

// >>> actuator_drive_config_register_test.sv
// self-checking bench for the drive config register block
// assumes a zero-wait ahb-lite slave and a small duty window of 16
`timescale 1ns/1ns
module actuator_drive_config_register_test;
   import adr_pkg::*;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010, device_mode = 3'h0;
   logic [31:0] hwdata = 32'h0, hrdata, d;
   logic        hreadyout, hresp, pin, run = 1'b0;
   logic [7:0]  period = 8'h04, high = 8'h01, level = 8'h00, analog;
   adr_byte_t   realtime_playback = 8'h00, input_amplitude, realtime_magnitude;
   logic        ecc, comp, rloop, rrate, commutation, amplitude_update;
   int          failures = 0, compares = 0, e, p;
   logic [7:0]  pat [4] = '{8'h3f, 8'hc0, 8'h15, 8'h2a};
   logic [7:0]  lvl [4] = '{8'h01, 8'h05, 8'h09, 8'h14};
   logic [7:0]  amp [4] = '{8'h01, 8'h05, 8'h00, 8'h14};
   // clock at 125 MHz
   always #4 hclk = ~hclk;
   adr_drive_config #(.DUTY_WIN(16)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .device_mode, .external_input_pin(pin), .analog_level(analog), .realtime_playback,
      .eccentric_mass_loop_select(ecc), .supply_compensation_off(comp),
      .resonant_loop_select(rloop), .resonant_update_rate(rrate), .input_amplitude,
      .realtime_magnitude, .commutation, .amplitude_update);
   adr_in_source src (.hclk, .run, .period, .high, .level, .pin, .analog);
   // comparison and report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %0t %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // one edge, with a bound on the whole run of waits
   task automatic tick(inout int n);
      @(posedge hclk);
      n++;
      if (n > 3000) begin
         failures++;
         give_verdict();
      end
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      do tick(n); while (hreadyout !== 1'b1);
   endtask
   // one single-word transfer, address phase then data phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      d = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
      bus(1'b0, a, 32'h0);
      check(d, exp, m);
   endtask
   // pin rises and update pulses over one full commutation period
   task automatic comm_period();
      int n;
      logic c, p0;
      n = 0;
      e = 0;
      p = 0;
      c = commutation;
      while (commutation === c) tick(n);
      p0 = pin;
      for (int k = 0; k < 2; k++) begin
         c = commutation;
         do begin
            tick(n);
            if (pin && !p0) e++;
            p0 = pin;
            if (amplitude_update === 1'b1) p++;
         end while (commutation === c);
      end
   endtask
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk(8'h00, 32'h80, "cfg reset");
      check(hresp, 1'b0, "okay response");
      check(hreadyout, 1'b1, "zero wait");
      $display("test reset done");
      // every field written and read back, control pins follow
      foreach (pat[i]) begin
         bus(1'b1, 8'h00, {24'hffffff, pat[i]});
         rdchk(8'h00, {24'h0, pat[i]}, "cfg readback");
         repeat (2) @(posedge hclk);
         check(ecc, pat[i][5], "eccentric loop");
         check(comp, pat[i][4], "compensation");
         check(rrate, pat[i][2], "update rate");
         check(rloop, pat[i][0], "resonant loop");
      end
      bus(1'b1, 8'h40, 32'hff);
      bus(1'b1, 8'h04, 32'hff);
      rdchk(8'h40, 32'h0, "unmapped read");
      rdchk(8'h00, 32'h2a, "cfg kept");
      $display("test fields done");
      // realtime data as signed, then unsigned
      realtime_playback <= 8'hf0;
      bus(1'b1, 8'h00, 32'h00);
      repeat (3) @(posedge hclk);
      check(realtime_magnitude, 8'h10, "signed magnitude");
      bus(1'b1, 8'h00, 32'h08);
      repeat (3) @(posedge hclk);
      check(realtime_magnitude, 8'hf0, "unsigned data");
      $display("test realtime done");
      // analog input through each gate level at its boundary
      device_mode <= 3'h3;
      foreach (lvl[g]) begin
         level <= lvl[g];
         bus(1'b1, 8'h00, {24'h0, g[1:0], 6'h02});
         repeat (8) @(posedge hclk);
         check(input_amplitude, amp[g], "analog gated");
      end
      rdchk(8'h04, 32'h828, "status analog path");
      level <= 8'h13;
      repeat (8) @(posedge hclk);
      check(input_amplitude, 8'h00, "eight percent gate");
      $display("test analog done");
      // pwm duty of one quarter, gate off
      run <= 1'b1;
      bus(1'b1, 8'h00, 32'h00);
      repeat (60) @(posedge hclk);
      check(input_amplitude, 8'h3f, "pwm duty");
      check(commutation, 1'b0, "no commutation closed loop");
      // open loop commutation, once and twice per cycle updates
      for (int r = 0; r < 2; r++) begin
         bus(1'b1, 8'h00, r ? 32'h05 : 32'h01);
         comm_period();
         check(e, 128, "edges per commutation");
         check(p, r + 1, "updates per commutation");
      end
      device_mode <= 3'h0;
      repeat (8) @(posedge hclk);
      check(commutation, 1'b0, "other mode stops commutation");
      $display("test pwm done");
      give_verdict();
   end
endmodule
